//--- src/sync_serial_pkg.sv
// Constants, types and helpers shared by the synchronous serial channel files
package sync_serial_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_SERIAL_CONTROL = 16'hFFA0;
    localparam logic [15:0] ADDR_SERIAL_CONTROL_STATUS = 16'hFFA1;
    localparam logic [15:0] ADDR_SHIFT_DATA_UPPER = 16'hFFA2;
    localparam logic [15:0] ADDR_SHIFT_DATA_LOWER = 16'hFFA3;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFFA4;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hFFA5;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SERIAL_CONTROL_STATUS_RESET = 8'h80;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int CLOCK_SOURCE_BIT = 3;
    localparam int DIVIDER_MSB = 2;
    localparam int SOL_BIT = 6;
    localparam int OVERRUN_BIT = 5;
    localparam int STATUS_SPARE_BIT = 1;
    localparam int START_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int IRQ_WIDTH = 2;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int PRESCALER_WIDTH = 10;
    localparam logic [4:0] LAST_BIT_8 = 5'h07;
    localparam logic [4:0] LAST_BIT_16 = 5'h0F;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_XFER8 = 2'h0,
        MODE_XFER16 = 2'h1,
        MODE_CONT_CLOCK = 2'h2,
        MODE_RESERVED = 2'h3
    } mode_t;

    // Counter bit whose toggling gives the selected division ratio
    function automatic logic [3:0] divider_tap(input logic [2:0] sel);
        case (sel)
            3'h0: divider_tap = 4'h9;
            3'h1: divider_tap = 4'h7;
            3'h2: divider_tap = 4'h5;
            3'h3: divider_tap = 4'h4;
            3'h4: divider_tap = 4'h3;
            3'h5: divider_tap = 4'h2;
            3'h6: divider_tap = 4'h1;
            default: divider_tap = 4'h0;
        endcase
    endfunction

endpackage

//--- src/serial_prescaler.sv
// Free-running prescaler giving the internal serial clock and its edge pulses
`timescale 1ns/1ns
module serial_prescaler (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] div_sel,
    output logic level,
    output logic fall,
    output logic rise
);
    typedef struct packed {
        logic [sync_serial_pkg::PRESCALER_WIDTH-1:0] cnt;
        logic level;
        logic fall;
        logic rise;
        logic [2:0] stable_cnt;
        logic [2:0] sel_prev;
    } presc_t;

    presc_t q;
    presc_t n;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Changing the ratio mid-stream may shorten one phase; no glitch guard
    always_comb begin
        n = q;
        n.cnt = q.cnt + 10'h001;
        n.level = n.cnt[sync_serial_pkg::divider_tap(div_sel)];
        n.fall = q.level & ~n.level;
        n.rise = ~q.level & n.level;
        n.sel_prev = div_sel;
        if (div_sel != q.sel_prev) begin
            n.stable_cnt = 3'h0;
        end else if (q.stable_cnt != 3'h7) begin
            n.stable_cnt = q.stable_cnt + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level = q.level;
    assign fall = q.fall;
    assign rise = q.rise;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_DIV_TWO: assert property ((div_sel == 3'h7 && q.sel_prev == 3'h7) |=>
        (q.level != $past(q.level))) else $error("divide by two does not toggle");
    AST_DIV_FOUR: assert property ((q.fall && q.sel_prev == 3'h6 &&
        q.stable_cnt >= 3'h5) |-> $past(q.fall, 4)) else $error("divide by four period wrong");

endmodule

//--- src/sync_serial_channel_control.sv
// Synchronous serial channel: registers, shift engine, clock pin and interrupt
//
// Summary of operation
// - Mode field 00 gives 8-bit transfer, 01 16-bit, 10 continuous clock, 11 reserved; resets 00.
// - Clock source bit 0 uses the prescaler and drives the clock pin out; this is the reset state.
// - Clock source bit 1 takes the shift clock from the clock pin as an input.
// - The divider field selects system clock over 1024, 256, 64, 32, 16, 8, 4 or 2.
// - Any write to the control register during a transfer aborts it.
// - Reset clears the control register to zero.
// - Control bits 5 and 4 are plain read/write storage with no effect.
// - Each completed transfer raises an interrupt request.
// - Continuous clock mode with clock source bit 0 drives the selected prescaler clock onto the clock pin nonstop.
// - Data go LSB first, output changes on falling clock edges, input sampled on rising ones.
// - Writing 1 to the start flag in mode 00 or 01 begins a transfer; it reads 1 until completion.
// - External clock: a pulse after completion sets overrun; read 1 then write 0 clears it.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module sync_serial_channel_control (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_in_pin,
    output logic serial_data_out_pin
);
    localparam int IRQ_W = sync_serial_pkg::IRQ_WIDTH;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WAIT,
        PH_SHIFT
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] ctrl;
        logic transfer_start_flag;
        logic overrun_flag;
        logic overrun_flag_armed;
        logic spare;
        logic [15:0] data;
        logic [4:0] cnt;
        logic done_seen;
        logic sdo;
        logic sclk_out;
        logic sclk_oe;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_prev;
        logic sdi_s1;
        logic sdi_s2;
        logic [7:0] rdata;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
    } state_t;

    // Clock pin stages start at the idle level so no false edge follows reset
    localparam state_t RESET_STATE = '{
        phase: PH_IDLE,
        ctrl: sync_serial_pkg::SERIAL_CONTROL_RESET,
        sclk_out: 1'b1,
        sclk_oe: 1'b1,
        sclk_s1: 1'b1,
        sclk_s2: 1'b1,
        sclk_prev: 1'b1,
        default: '0
    };

    state_t q;
    state_t n;

    logic p_level;
    logic p_fall;
    logic p_rise;
    logic ext_clk;
    sync_serial_pkg::mode_t mode;
    logic rise;
    logic fall;
    logic [4:0] last_bit;
    logic done_ev;
    logic ovr_ev;
    logic ctrl_wr;
    logic stat_wr;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    serial_prescaler u_prescaler (
        .mclk(mclk),
        .rst(rst),
        .div_sel(q.ctrl[sync_serial_pkg::DIVIDER_MSB:0]),
        .level(p_level),
        .fall(p_fall),
        .rise(p_rise)
    );

    // Decoded controls and the shift clock edges of the active source
    always_comb begin
        ext_clk = q.ctrl[sync_serial_pkg::CLOCK_SOURCE_BIT];
        mode = sync_serial_pkg::mode_t'(
            q.ctrl[sync_serial_pkg::MODE_MSB:sync_serial_pkg::MODE_LSB]);
        rise = ext_clk ? (q.sclk_s2 & ~q.sclk_prev) : p_rise;
        fall = ext_clk ? (~q.sclk_s2 & q.sclk_prev) : p_fall;
        last_bit = (mode == sync_serial_pkg::MODE_XFER16) ? sync_serial_pkg::LAST_BIT_16 :
            sync_serial_pkg::LAST_BIT_8;
        ctrl_wr = wr && addr == sync_serial_pkg::ADDR_SERIAL_CONTROL;
        stat_wr = wr && addr == sync_serial_pkg::ADDR_SERIAL_CONTROL_STATUS;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        done_ev = 1'b0;
        ovr_ev = 1'b0;

        // Pin synchronisers; only stage two feeds the edge logic
        n.sclk_s1 = serial_clock_pin_in;
        n.sclk_s2 = q.sclk_s1;
        n.sclk_prev = q.sclk_s2;
        n.sdi_s1 = serial_data_in_pin;
        n.sdi_s2 = q.sdi_s1;

        // Register reads; answer one cycle later, unmapped reads give zero
        n.rdata = 8'h00;
        if (rd) begin
            case (addr)
                sync_serial_pkg::ADDR_SERIAL_CONTROL: n.rdata = q.ctrl;
                sync_serial_pkg::ADDR_SERIAL_CONTROL_STATUS: begin
                    n.rdata = {1'b1, q.sdo, q.overrun_flag, 3'b000, q.spare, q.transfer_start_flag};
                    if (q.overrun_flag) begin
                        n.overrun_flag_armed = 1'b1;
                    end
                end
                sync_serial_pkg::ADDR_SHIFT_DATA_UPPER: n.rdata = q.data[15:8];
                sync_serial_pkg::ADDR_SHIFT_DATA_LOWER: n.rdata = q.data[7:0];
                sync_serial_pkg::ADDR_IRQ_STATUS: n.rdata = {6'h00, q.irq_stat};
                sync_serial_pkg::ADDR_IRQ_MASK: n.rdata = {6'h00, q.irq_mask};
                default: n.rdata = 8'h00;
            endcase
        end

        // Shift engine
        case (q.phase)
            PH_IDLE: begin
                // Stray pulse after completion means the partner ran ahead
                if (ext_clk && rise && q.done_seen &&
                    mode != sync_serial_pkg::MODE_CONT_CLOCK) begin
                    ovr_ev = 1'b1;
                end
            end
            PH_WAIT: begin
                if (fall) begin
                    n.sdo = q.data[0];
                    n.cnt = 5'h00;
                    n.phase = PH_SHIFT;
                end
            end
            PH_SHIFT: begin
                if (rise) begin
                    if (mode == sync_serial_pkg::MODE_XFER16) begin
                        n.data = {q.sdi_s2, q.data[15:1]};
                    end else begin
                        n.data[7:0] = {q.sdi_s2, q.data[7:1]};
                    end
                    if (q.cnt == last_bit) begin
                        n.phase = PH_IDLE;
                        n.transfer_start_flag = 1'b0;
                        n.done_seen = 1'b1;
                        done_ev = 1'b1;
                    end else begin
                        n.cnt = q.cnt + 5'h01;
                    end
                end else if (fall) begin
                    n.sdo = q.data[0];
                end
            end
            default: n.phase = PH_IDLE;
        endcase

        // Register writes take priority over the engine, except that an overrun event wins over its clear
        if (ctrl_wr) begin
            n.ctrl = wdata;
            n.phase = PH_IDLE;
            n.transfer_start_flag = 1'b0;
        end
        if (stat_wr) begin
            if (q.phase == PH_IDLE) begin
                n.sdo = wdata[sync_serial_pkg::SOL_BIT];
            end
            n.spare = wdata[sync_serial_pkg::STATUS_SPARE_BIT];
            // Reserved and continuous modes have no transfer to start
            if (wdata[sync_serial_pkg::START_BIT] && q.phase == PH_IDLE &&
                !q.ctrl[sync_serial_pkg::MODE_MSB]) begin
                n.transfer_start_flag = 1'b1;
                n.phase = PH_WAIT;
                n.done_seen = 1'b0;
            end
            if (!wdata[sync_serial_pkg::OVERRUN_BIT] && q.overrun_flag_armed) begin
                n.overrun_flag = 1'b0;
                n.overrun_flag_armed = 1'b0;
            end
        end
        if (wr && addr == sync_serial_pkg::ADDR_SHIFT_DATA_UPPER) begin
            n.data[15:8] = wdata;
        end
        if (wr && addr == sync_serial_pkg::ADDR_SHIFT_DATA_LOWER) begin
            n.data[7:0] = wdata;
        end
        if (ovr_ev) begin
            n.overrun_flag = 1'b1;
        end

        // Interrupt: read clears, a same-cycle event still sets
        if (rd && addr == sync_serial_pkg::ADDR_IRQ_STATUS) begin
            n.irq_stat = '0;
        end
        n.irq_stat[sync_serial_pkg::IRQ_DONE_BIT] = n.irq_stat[sync_serial_pkg::IRQ_DONE_BIT] |
            done_ev;
        n.irq_stat[sync_serial_pkg::IRQ_OVERRUN_BIT] =
            n.irq_stat[sync_serial_pkg::IRQ_OVERRUN_BIT] | ovr_ev;
        if (wr && addr == sync_serial_pkg::ADDR_IRQ_MASK) begin
            n.irq_mask = wdata[IRQ_W-1:0];
        end
        n.irq = |(n.irq_stat & n.irq_mask);

        // Clock pin idles high; continuous mode runs the prescaler nonstop
        n.sclk_oe = !ext_clk;
        if (mode == sync_serial_pkg::MODE_CONT_CLOCK || q.phase == PH_SHIFT ||
            (q.phase == PH_WAIT && p_fall)) begin
            n.sclk_out = p_level;
        end else begin
            n.sclk_out = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= n;
        end
    end

    assign rdata = q.rdata;
    assign irq = q.irq;
    assign serial_clock_pin_out = q.sclk_out;
    assign serial_clock_pin_oe = q.sclk_oe;
    assign serial_data_out_pin = q.sdo;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_RESET_CTRL: assert property (disable iff (1'b0) rst |=>
        (q.ctrl == 8'h00 && q.sclk_oe && !q.transfer_start_flag)) else $error("control not cleared by reset");
    AST_OE_INTERNAL: assert property (!ext_clk |=> serial_clock_pin_oe)
        else $error("clock pin not driven with internal source");
    AST_OE_EXTERNAL: assert property (ext_clk |=> !serial_clock_pin_oe)
        else $error("clock pin driven with external source");
    AST_CONT_CLOCK: assert property (mode == sync_serial_pkg::MODE_CONT_CLOCK |=>
        (serial_clock_pin_out == $past(p_level))) else $error("continuous clock not on pin");
    AST_ABORT: assert property (ctrl_wr |=> (!q.transfer_start_flag && q.phase == PH_IDLE))
        else $error("control write did not abort");
    AST_SPARE_STORE: assert property (ctrl_wr |=> (q.ctrl[5:4] == $past(wdata[5:4])))
        else $error("spare control bits not stored");
    AST_START: assert property ((stat_wr && wdata[0] && q.phase == PH_IDLE &&
        mode == sync_serial_pkg::MODE_XFER8) |=> (q.transfer_start_flag && q.phase == PH_WAIT))
        else $error("start flag write did not start");
    AST_DONE_IRQ: assert property ((q.phase == PH_SHIFT && rise && q.cnt == last_bit &&
        !ctrl_wr) |=> (q.irq_stat[0] && !q.transfer_start_flag && q.phase == PH_IDLE))
        else $error("completion not flagged");
    AST_LEN16: assert property ((q.phase == PH_SHIFT && rise && q.cnt == 5'h07 &&
        mode == sync_serial_pkg::MODE_XFER16 && !ctrl_wr) |=> q.phase == PH_SHIFT)
        else $error("16-bit transfer ended after 8 bits");
    AST_LSB_OUT: assert property ((q.phase == PH_WAIT && fall && !stat_wr && !ctrl_wr) |=>
        (serial_data_out_pin == $past(q.data[0]))) else $error("first bit is not the LSB");
    AST_SAMPLE: assert property ((q.phase == PH_SHIFT && rise && !ctrl_wr &&
        mode == sync_serial_pkg::MODE_XFER8) |=> (q.data[7] == $past(q.sdi_s2)))
        else $error("input not sampled on rising edge");
    AST_OVERRUN: assert property ((q.phase == PH_IDLE && ext_clk && rise && q.done_seen &&
        mode != sync_serial_pkg::MODE_CONT_CLOCK) |=> q.overrun_flag) else $error("overrun not flagged");
    AST_IRQ_OUT: assert property ((q.irq_stat & q.irq_mask) != '0 |-> irq)
        else $error("unmasked status without interrupt");

    COV_XFER16: cover property (q.phase == PH_SHIFT && mode == sync_serial_pkg::MODE_XFER16
        ##1 q.phase == PH_IDLE);
    COV_OVERRUN: cover property (ovr_ev);
    COV_CONT: cover property (mode == sync_serial_pkg::MODE_CONT_CLOCK && p_fall);
    COV_ABORT: cover property (q.phase == PH_SHIFT && ctrl_wr);

endmodule

//--- dv/serial_peer_model.sv
// Behavioural external serial party: clock source, shifter and receiver
`timescale 1ns/1ns
module serial_peer_model (
    input wire logic mclk,
    input wire logic sck,
    input wire logic sdo,
    input wire logic load,
    input wire logic go,
    input wire logic [15:0] tx_word,
    input wire logic [5:0] pulses,
    output logic sdi,
    output logic ext_clk,
    output logic [15:0] rx_word
);
    logic sck_q = 1'b1;
    logic [15:0] tx_q = 16'h0000;
    logic [5:0] left_q = 6'h00;
    logic [2:0] half_q = 3'h0;

    initial begin
        sdi = 1'b0;
        ext_clk = 1'b1;
        rx_word = 16'h0000;
    end

    // Shift out on falling pin edges, capture on rising ones, LSB first
    always @(posedge mclk) begin
        sck_q <= sck;
        if (load) begin
            tx_q <= tx_word;
            sdi <= ~tx_word[0];
            rx_word <= 16'h0000;
        end else if (sck_q && !sck) begin
            sdi <= tx_q[0];
            tx_q <= {~tx_q[0], tx_q[15:1]};
        end
        if (!load && !sck_q && sck) begin
            rx_word <= {sdo, rx_word[15:1]};
        end
    end

    // Clock bursts; the clock stands high between bursts
    always @(posedge mclk) begin
        if (go) begin
            left_q <= pulses;
            half_q <= 3'h0;
        end else if (left_q != 6'h00) begin
            half_q <= half_q + 3'h1;
            if (half_q == 3'h7) begin
                ext_clk <= ~ext_clk;
                if (!ext_clk) begin
                    left_q <= left_q - 6'h01;
                end
            end
        end
    end
endmodule

//--- dv/sync_serial_channel_control_tb.sv
// Self-checking bench for the synchronous serial channel
`timescale 1ns/1ns
module sync_serial_channel_control_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [15:0] A_CTL = sync_serial_pkg::ADDR_SERIAL_CONTROL;
    localparam logic [15:0] A_STA = sync_serial_pkg::ADDR_SERIAL_CONTROL_STATUS;
    localparam logic [15:0] A_UPP = sync_serial_pkg::ADDR_SHIFT_DATA_UPPER;
    localparam logic [15:0] A_LOW = sync_serial_pkg::ADDR_SHIFT_DATA_LOWER;
    localparam logic [15:0] A_IRQ = sync_serial_pkg::ADDR_IRQ_STATUS;
    localparam logic [15:0] A_MSK = sync_serial_pkg::ADDR_IRQ_MASK;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic load = 1'b0;
    logic go = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic [5:0] pulses = 6'h00;
    logic [7:0] rdata;
    logic irq, sck_out, sck_oe, sdi, sdo, ext_clk, sck_wire;
    logic [15:0] rx_word;
    logic sck_prev = 1'b1;
    logic [15:0] gap = 16'h0000;
    logic [15:0] period = 16'h0000;
    logic [7:0] d;
    int fails = 0;
    int checks_done = 0;

    // Pin level: the design when enabled, the peer otherwise
    assign sck_wire = sck_oe ? sck_out : ext_clk;

    always #20 mclk = ~mclk;

    sync_serial_channel_control u_sync_serial_channel_control (.mclk(mclk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .serial_clock_pin_in(sck_wire), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe(sck_oe), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));

    serial_peer_model u_serial_peer_model (.mclk(mclk), .sck(sck_wire), .sdo(sdo),
        .load(load), .go(go), .tx_word(tx_word), .pulses(pulses), .sdi(sdi),
        .ext_clk(ext_clk), .rx_word(rx_word));

    // Cycles between falling edges of the clock pin
    always @(posedge mclk) begin
        sck_prev <= sck_wire;
        gap <= gap + 16'h0001;
        if (sck_prev && !sck_wire) begin
            period <= gap;
            gap <= 16'h0001;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        v = rdata;
    endtask

    // Bounded poll of the busy flag
    task automatic wait_idle();
        for (int i = 0; i < 3000; i++) begin
            rd_reg(A_STA, d);
            if (d[0] === 1'b0) break;
        end
        // A poll that runs out leaves the busy flag set and counts as a mismatch
        chk(d[0], 1'b0);
    endtask

    task automatic peer_cmd(input logic [15:0] w, input logic [5:0] n, input logic is_go);
        @(posedge mclk);
        tx_word <= w;
        pulses <= n;
        load <= !is_go;
        go <= is_go;
        @(posedge mclk);
        load <= 1'b0;
        go <= 1'b0;
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic t_reset();
        rd_reg(A_CTL, d);
        chk(d, 8'h00);
        rd_reg(A_STA, d);
        chk(d, 8'h80);
        rd_reg(16'hFFB0, d);
        chk(d, 8'h00);
        chk(sck_oe, 1'b1);
        $display("test reset done");
    endtask

    // Every divider in continuous mode; data pins left alone
    task automatic t_cont();
        int div [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
        for (int s = 0; s < 8; s++) begin
            wr_reg(A_CTL, {5'b10000, s[2:0]});
            repeat (3 * div[s] + 8) @(posedge mclk);
            @(negedge mclk);
            chk(period, 16'(div[s]));
            chk(sck_oe, 1'b1);
        end
        wr_reg(A_CTL, 8'h00);
        $display("test continuous clock done");
    endtask

    // Spare bits set must not disturb an 8-bit internal transfer
    task automatic t_xfer8();
        wr_reg(A_CTL, 8'h34);
        rd_reg(A_CTL, d);
        chk(d, 8'h34);
        wr_reg(A_MSK, 8'h00);
        wr_reg(A_LOW, 8'hA5);
        peer_cmd(16'h003C, 6'h00, 1'b0);
        wr_reg(A_STA, 8'h01);
        rd_reg(A_STA, d);
        chk(d[0], 1'b1);
        wait_idle();
        chk(period, 16'h0010);
        chk(rx_word[15:8], 8'hA5);
        rd_reg(A_LOW, d);
        chk(d, 8'h3C);
        chk(irq, 1'b0);
        wr_reg(A_MSK, 8'h01);
        repeat (2) @(negedge mclk);
        chk(irq, 1'b1);
        rd_reg(A_IRQ, d);
        chk(d, 8'h01);
        repeat (2) @(negedge mclk);
        chk(irq, 1'b0);
        $display("test 8-bit transfer done");
    endtask

    // 16-bit transfer on the peer clock, then one stray pulse
    task automatic t_xfer16();
        wr_reg(A_CTL, 8'h48);
        wr_reg(A_UPP, 8'h12);
        wr_reg(A_LOW, 8'h34);
        chk(sck_oe, 1'b0);
        peer_cmd(16'hBEEF, 6'h00, 1'b0);
        wr_reg(A_STA, 8'h01);
        repeat (20) @(posedge mclk);
        rd_reg(A_STA, d);
        chk(d[0], 1'b1);
        peer_cmd(16'h0000, 6'h10, 1'b1);
        wait_idle();
        chk(rx_word, 16'h1234);
        rd_reg(A_UPP, d);
        chk(d, 8'hBE);
        rd_reg(A_LOW, d);
        chk(d, 8'hEF);
        peer_cmd(16'h0000, 6'h01, 1'b1);
        repeat (40) @(posedge mclk);
        rd_reg(A_STA, d);
        chk(d, 8'hA0);
        rd_reg(A_IRQ, d);
        chk(d, 8'h03);
        wr_reg(A_STA, 8'h00);
        rd_reg(A_STA, d);
        chk(d, 8'h80);
        $display("test 16-bit external done");
    endtask

    // Control write in mid-transfer stops it without a completion event
    task automatic t_abort();
        wr_reg(A_CTL, 8'h00);
        wr_reg(A_STA, 8'h01);
        repeat (3000) @(posedge mclk);
        rd_reg(A_STA, d);
        chk(d[0], 1'b1);
        wr_reg(A_CTL, 8'h00);
        rd_reg(A_STA, d);
        chk(d[0], 1'b0);
        repeat (100) @(posedge mclk);
        rd_reg(A_IRQ, d);
        chk(d, 8'h00);
        $display("test abort done");
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_cont();
        t_xfer8();
        t_xfer16();
        t_abort();
        end_sim();
    end

    // Whole run needs about 8000 cycles
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        $display("Watchdog expired");
        end_sim();
    end
endmodule
